//--- core/smsp_port.sv
// Purpose: Eight-bit SPI port, master or slave, with an APB register file.
// Assumes: pclk is the oscillator; pins are asynchronous and are synchronised here.
// Notes: Zero-wait APB slave; read data is captured in the setup cycle.
`timescale 1ns/1ps
`include "smsp_defs.svh"
module smsp_port import smsp_pkg::*; (
   // Clock, reset and freeze.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Device state and timer.
   input wire logic sleep,
   input wire logic timer_match,
   // Serial pins.
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic sdo_oe,
   input wire logic ss_a_n,
   input wire logic ss_b_n
);
   smsp_core_s st_q, st_d;
   smsp_rate_if rif ();
   logic [3:0] pins_s;
   logic sck_s, sdi_s, ss_s;
   logic is_master, is_slave, ss_hold, busy;
   logic wr_acc, rd_setup, rd_acc, mapped;
   logic [4:0] tt;
   logic lead, trail, smp_now, shift_now, bit_in;
   logic done_m, done_s;
   logic [7:0] rx_byte;

   // Pin inputs pass two flops before any use.
   smsp_sync #(.W(4)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .d({sck_in, serial_data_in, ss_a_n, ss_b_n}),
      .q(pins_s)
   );
   assign sck_s = pins_s[3];
   assign sdi_s = pins_s[2];
   // The select source is chosen after synchronising both pins.
   assign ss_s = st_q.sel_pin ? pins_s[0] : pins_s[1];

   // Bit-rate generator; it stops ticking in sleep so the transfer freezes.
   assign rif.rate_sel = st_q.mode[1:0];
   assign rif.run = (st_q.mst == MST_RUN) && !sleep;
   assign rif.timer_pulse = timer_match;
   smsp_rate u_rate (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .rif(rif)
   );

   // Mode decode.
   assign is_master = st_q.en && (st_q.mode[3:2] == 2'b00);
   assign is_slave = st_q.en && ((st_q.mode == `SMSP_MODE_SLV_SS) || (st_q.mode == `SMSP_MODE_SLV));
   assign ss_hold = is_slave && (st_q.mode == `SMSP_MODE_SLV_SS) && ss_s;

   // A byte is in flight while the master runs or the slave has seen a clock.
   assign busy = (st_q.mst == MST_RUN) || (st_q.slv_cnt != 3'd0) || st_q.slv_valid;

   // APB decode: writes and read side effects act in the access phase only.
   assign mapped = (paddr == `SMSP_OFF_CONTROL) || (paddr == `SMSP_OFF_STATUS) ||
                   (paddr == `SMSP_OFF_BUFFER) || (paddr == `SMSP_OFF_ALTPIN) ||
                   (paddr == `SMSP_OFF_IRQ);
   assign wr_acc = psel && penable && pwrite && mapped;
   assign rd_setup = psel && !penable && !pwrite;
   assign rd_acc = psel && penable && !pwrite && (paddr == `SMSP_OFF_BUFFER);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Master edge timing. Edges are numbered 1 to 16; odd ones leave the idle level.
   assign tt = st_q.edge_cnt + 5'd1;
   always_comb begin
      if (st_q.late) begin
         smp_now = st_q.cke ? !tt[0] : (tt[0] && tt != 5'd1) || tt == `SMSP_LAST_EDGE;
      end else begin
         smp_now = st_q.cke ? tt[0] : !tt[0];
      end
      // With edge select set the next bit is put out on the trailing edge, ahead of its edge.
      if (st_q.cke) shift_now = !tt[0] && tt != `SMSP_LAST_EDGE;
      else shift_now = tt[0] && tt != 5'd1;
   end

   // Slave edges from the synchronised clock, relative to the idle level.
   assign lead = (st_q.sck_prev == st_q.idle) && (sck_s != st_q.idle);
   assign trail = (st_q.sck_prev != st_q.idle) && (sck_s == st_q.idle);

   // Completion of the eighth bit in either role.
   assign done_m = is_master && (st_q.mst == MST_RUN) && rif.tick && tt == `SMSP_LAST_EDGE;
   assign done_s = is_slave && !ss_hold && !st_q.sov && (st_q.cke ? lead : trail) &&
                   st_q.slv_cnt == 3'd7;
   always_comb begin
      bit_in = (done_m && !smp_now) ? st_q.samp : sdi_s;
      rx_byte = {st_q.shreg[6:0], bit_in};
   end

   // Next-state logic for the whole core.
   always_comb begin
      st_d = st_q;
      st_d.sck_prev = sck_s;

      // Register writes.
      if (wr_acc && paddr == `SMSP_OFF_CONTROL) begin
         st_d.coll = st_q.coll && pwdata[`SMSP_CTL_COLL];
         st_d.sov = st_q.sov && pwdata[`SMSP_CTL_SOV];
         st_d.en = pwdata[`SMSP_CTL_EN];
         st_d.idle = pwdata[`SMSP_CTL_IDLE];
         st_d.mode = pwdata[3:0];
      end
      if (wr_acc && paddr == `SMSP_OFF_STATUS) begin
         st_d.late = pwdata[`SMSP_STA_LATE];
         st_d.cke = pwdata[`SMSP_STA_CKE];
         st_d.sdo_rel = pwdata[`SMSP_STA_SDOREL];
      end
      if (wr_acc && paddr == `SMSP_OFF_ALTPIN) begin
         st_d.sel_pin = pwdata[0];
      end
      if (wr_acc && paddr == `SMSP_OFF_IRQ) begin
         st_d.irq = st_q.irq && pwdata[0];
      end

      // Buffer write: loads the shifter when idle, else is dropped.
      if (wr_acc && paddr == `SMSP_OFF_BUFFER) begin
         if (busy) begin
            st_d.coll = 1'b1;
         end else begin
            st_d.xbuf = pwdata[7:0];
            st_d.shreg = pwdata[7:0];
            if (is_master) begin
               st_d.mst = MST_RUN;
               st_d.edge_cnt = 5'd0;
            end
         end
      end

      // Reading the buffer empties it; a same-cycle completion still sets it below.
      if (rd_acc) st_d.full = 1'b0;

      // Master shifting, one step per half period.
      if (is_master && st_q.mst == MST_RUN && rif.tick) begin
         st_d.edge_cnt = tt;
         if (smp_now) st_d.samp = sdi_s;
         if (shift_now) st_d.shreg = {st_q.shreg[6:0], smp_now ? sdi_s : st_q.samp};
         if (done_m) begin
            st_d.mst = MST_IDLE;
            st_d.edge_cnt = 5'd0;
            st_d.shreg = rx_byte;
            st_d.xbuf = rx_byte;
            st_d.full = 1'b1;
            st_d.irq = 1'b1;
         end
      end

      // Slave shifting on the external clock; it keeps going in sleep.
      if (is_slave && !ss_hold && !st_q.sov) begin
         if (st_q.cke ? trail : lead) begin
            if (st_q.slv_valid) begin
               st_d.shreg = {st_q.shreg[6:0], st_q.samp};
               st_d.slv_valid = 1'b0;
            end
         end
         if (st_q.cke ? lead : trail) begin
            if (done_s) begin
               st_d.slv_cnt = 3'd0;
               st_d.slv_valid = 1'b0;
               st_d.shreg = rx_byte;
               st_d.irq = 1'b1;
               if (st_q.full && !rd_acc) begin
                  st_d.sov = 1'b1;
               end else begin
                  st_d.xbuf = rx_byte;
                  st_d.full = 1'b1;
               end
            end else begin
               st_d.slv_cnt = st_q.slv_cnt + 3'd1;
               st_d.samp = sdi_s;
               st_d.slv_valid = 1'b1;
            end
         end
      end

      // Select high holds the slave bit logic in reset.
      if (ss_hold) begin
         st_d.slv_cnt = 3'd0;
         st_d.slv_valid = 1'b0;
      end

      // A disabled port, or one left in the wrong role, restarts at bit zero.
      if (!st_q.en || !is_master) begin
         st_d.mst = MST_IDLE;
         st_d.edge_cnt = 5'd0;
      end
      if (!st_q.en || !is_slave) begin
         st_d.slv_cnt = 3'd0;
         st_d.slv_valid = 1'b0;
      end

      // Pin drivers, registered. The clock idles at the chosen level.
      st_d.sck_q = st_d.idle ^ ((st_d.mst == MST_RUN) && st_d.edge_cnt[0]);
      st_d.sdo_q = st_d.shreg[7];

      // Read data is captured in the setup cycle and shown in the access cycle.
      if (rd_setup) begin
         st_d.prdata = 32'h0000_0000;
         unique case (paddr)
            `SMSP_OFF_CONTROL: st_d.prdata[7:0] = {st_q.coll, st_q.sov, st_q.en, st_q.idle, st_q.mode};
            `SMSP_OFF_STATUS: st_d.prdata[7:0] = {st_q.late, st_q.cke, st_q.sdo_rel, 4'h0, st_q.full};
            `SMSP_OFF_BUFFER: st_d.prdata[7:0] = st_q.xbuf;
            `SMSP_OFF_ALTPIN: st_d.prdata[0] = st_q.sel_pin;
            `SMSP_OFF_IRQ: st_d.prdata[0] = st_q.irq;
            default: st_d.prdata = 32'h0000_0000;
         endcase
      end
   end

   // State register; the clock enable freezes everything, the flags included.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
         st_q.mode <= 4'(`SMSP_CONTROL_RST);
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   // Pin outputs. The clock is driven only by a master; a slave only listens.
   assign sck_out = st_q.sck_q;
   assign sck_oe = is_master;
   assign serial_data_out = st_q.sdo_q;
   // Releasing the data output leaves input sampling untouched.
   assign sdo_oe = (is_master || is_slave) && !st_q.sdo_rel && !ss_hold;
   assign prdata = st_q.prdata;
endmodule : smsp_port

//--- core/smsp_defs.svh
// Purpose: Offsets, field positions, reset values and rate counts of the serial port.
// Assumes: APB byte addresses, 32-bit data, each register one aligned word.
// Notes: Tags below mark the logic that carries each rule.
// Operation
// - Eight bits out and in together
// - Most significant bit first, both directions
// - Only the master drives serial clock
// - Eighth bit copies byte, sets flags
// - Write during shifting dropped, collision set
// - Collision flag cleared only by software
// - Buffer read clears buffer full
// - Master buffer write starts transfer at once
// - Rate divide 4, 16, 64 or timer
// - Clock idle level from setting
// - Edge select presents data before edge
// - Master samples at middle or end
// - Master sleep freezes transfer, then resumes
// - Slave shifts one bit per pulse
// - Slave overrun sets flag, stops traffic
// - Enable activates; clear to reconfigure
// - Enabled port owns data and clock pins
// - Slave select from one of two pins
// - Master keeps sampling with output released
// - Shift register reachable only via buffer
// - Select high resets slave, floats output
// - Slave shifts in sleep, flags completion
`ifndef SMSP_DEFS_SVH
`define SMSP_DEFS_SVH
`define SMSP_OFF_CONTROL 8'h00
`define SMSP_OFF_STATUS 8'h04
`define SMSP_OFF_BUFFER 8'h08
`define SMSP_OFF_ALTPIN 8'h0C
`define SMSP_OFF_IRQ 8'h10
`define SMSP_CTL_COLL 7
`define SMSP_CTL_SOV 6
`define SMSP_CTL_EN 5
`define SMSP_CTL_IDLE 4
`define SMSP_STA_LATE 7
`define SMSP_STA_CKE 6
`define SMSP_STA_SDOREL 5
`define SMSP_STA_FULL 0
`define SMSP_MODE_DIV4 4'h0
`define SMSP_MODE_DIV16 4'h1
`define SMSP_MODE_DIV64 4'h2
`define SMSP_MODE_TIMER 4'h3
`define SMSP_MODE_SLV_SS 4'h4
`define SMSP_MODE_SLV 4'h5
`define SMSP_CONTROL_RST 8'h00
`define SMSP_HALF_DIV4 5'd2
`define SMSP_HALF_DIV16 5'd8
`define SMSP_HALF_DIV64 6'd32
`define SMSP_LAST_EDGE 5'd16
`endif

//--- core/smsp_pkg.sv
// Purpose: Types shared by the serial port modules.
// Assumes: Constants come from smsp_defs.svh.
// Notes: Core state is one packed struct registered as a whole.
package smsp_pkg;
   typedef enum logic {MST_IDLE, MST_RUN} smsp_mst_e;
   typedef struct packed {
      smsp_mst_e mst;
      logic [4:0] edge_cnt;
      logic samp;
      logic [2:0] slv_cnt;
      logic slv_valid;
      logic sck_prev;
      logic [7:0] shreg;
      logic [7:0] xbuf;
      logic full;
      logic irq;
      logic coll;
      logic sov;
      logic en;
      logic idle;
      logic [3:0] mode;
      logic late;
      logic cke;
      logic sdo_rel;
      logic sel_pin;
      logic sck_q;
      logic sdo_q;
      logic [31:0] prdata;
   } smsp_core_s;
endpackage : smsp_pkg

//--- core/smsp_rate_if.sv
// Purpose: Link between the port core and its bit-rate generator.
// Assumes: One clock domain.
// Notes: Tick marks one serial clock half period.
`timescale 1ns/1ps
interface smsp_rate_if;
   logic [1:0] rate_sel;
   logic run;
   logic timer_pulse;
   logic tick;
   modport core (output rate_sel, output run, output timer_pulse, input tick);
   modport gen (input rate_sel, input run, input timer_pulse, output tick);
endinterface : smsp_rate_if

//--- core/smsp_sync.sv
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to pclk.
// Notes: Only the second stage leaves this module.
`timescale 1ns/1ps
module smsp_sync #(parameter int W = 1) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Data.
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {logic [W-1:0] s1; logic [W-1:0] s2;} smsp_sync_s;
   smsp_sync_s st_q, st_d;
   if (W < 1) begin : g_chk
      $error("Synchroniser width must be at least one.");
   end
   // The first stage feeds only the second stage.
   always_comb begin
      st_d = st_q;
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) st_q <= '0;
      else if (ce) st_q <= st_d;
   end
   assign q = st_q.s2;
endmodule : smsp_sync

//--- core/smsp_rate.sv
// Purpose: Half period tick generator for master serial clock.
// Assumes: pclk is the oscillator; timer pulse is one pclk wide.
// Notes: Counter restarts whenever run is low.
`timescale 1ns/1ps
`include "smsp_defs.svh"
module smsp_rate (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Core link.
   smsp_rate_if.gen rif
);
   typedef struct packed {logic [4:0] cnt;} smsp_rate_s;
   smsp_rate_s st_q, st_d;
   logic [4:0] half;
   // One timer match is half of the timer-derived bit period.
   always_comb begin
      st_d = st_q;
      unique case (rif.rate_sel)
         2'd0: half = `SMSP_HALF_DIV4;
         2'd1: half = `SMSP_HALF_DIV16;
         default: half = 5'(`SMSP_HALF_DIV64 - 6'd1);
      endcase
      if (rif.rate_sel == 2'd2) rif.tick = rif.run && (st_q.cnt == half);
      else if (rif.rate_sel == 2'd3) rif.tick = rif.run && rif.timer_pulse;
      else rif.tick = rif.run && (st_q.cnt == half - 5'd1);
      if (!rif.run || rif.tick) st_d.cnt = 5'd0;
      else st_d.cnt = st_q.cnt + 5'd1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) st_q <= '0;
      else if (ce) st_q <= st_d;
   end
endmodule : smsp_rate

//--- tb/smsp_port_chk.sv
// Purpose: Assertions on the serial port pins and APB answers.
// Assumes: Control and alt pin writes are shadowed from the bus.
// Notes: Modes 6 to 15 count as neither master nor slave.
`timescale 1ns/1ps
`include "smsp_defs.svh"
module smsp_port_chk (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Device state and pins.
   input wire logic sleep,
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic serial_data_out,
   input wire logic sdo_oe,
   input wire logic ss_a_n,
   input wire logic ss_b_n
);
   logic [3:0] mode_q;
   logic en_q;
   logic sel_q;
   logic wr_acc;
   logic mst;
   // A copy of the settings kept from the bus, so a core that misreads its own writes shows up here.
   assign wr_acc = psel && penable && pwrite && ce;
   assign mst = en_q && mode_q <= 4'h3;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= 4'h0;
         en_q <= 1'b0;
         sel_q <= 1'b0;
      end else begin
         if (wr_acc && paddr == `SMSP_OFF_CONTROL) begin
            mode_q <= pwdata[3:0];
            en_q <= pwdata[`SMSP_CTL_EN];
         end
         if (wr_acc && paddr == `SMSP_OFF_ALTPIN) begin
            sel_q <= pwdata[0];
         end
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Bus answers.
   a_ready_zero: assert property (psel && penable |-> pready)
      else $error("access not answered at once");
   a_slverr_map: assert property (psel && penable |-> pslverr == !(paddr inside {`SMSP_OFF_CONTROL,
      `SMSP_OFF_STATUS, `SMSP_OFF_BUFFER, `SMSP_OFF_ALTPIN, `SMSP_OFF_IRQ})) else $error("bad error answer");
   a_err_rdata: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0000_0000)
      else $error("refused read returned data");
   // Pin ownership.
   a_master_oe: assert property (mst |-> sck_oe) else $error("master not driving clock");
   a_slave_noclk: assert property (en_q && mode_q inside {4'h4, 4'h5} |-> !sck_oe)
      else $error("slave drives clock");
   a_disabled_off: assert property (!en_q |-> !sck_oe && !sdo_oe)
      else $error("disabled port drives pins");
   // Bit rate at f/4 and f/16, sleep freeze and select hold; a half period never ends early.
   a_rate_fast: assert property (mst && mode_q == 4'h0 && $changed(sck_out) && $past(sck_oe) |=>
      $stable(sck_out)) else $error("half period under two cycles");
   a_rate_mid: assert property (mst && mode_q == 4'h1 && $changed(sck_out) && $past(sck_oe) |=>
      $stable(sck_out) [*7]) else $error("half period under eight cycles");
   a_sleep_freeze: assert property (mst && sleep && $past(sleep) && $past(sleep, 2) |->
      $stable(sck_out) && $stable(serial_data_out)) else $error("master moved in sleep");
   a_select_hold: assert property ((en_q && mode_q == 4'h4 && (sel_q ? ss_b_n : ss_a_n)) [*4] |->
      !sdo_oe) else $error("deselected slave drives data");
endmodule : smsp_port_chk
bind smsp_port smsp_port_chk chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sleep(sleep), .sck_out(sck_out), .sck_oe(sck_oe), .serial_data_out(serial_data_out), .sdo_oe(sdo_oe), .ss_a_n(ss_a_n),
   .ss_b_n(ss_b_n));

//--- tb/smsp_peer.sv
// Purpose: Far-side SPI party: slave to a master port, master to a slave port.
// Assumes: Clock idles low; data changes on the trailing edge, is sampled on the leading one.
// Notes: The bit count is never resynchronised, so only whole bytes may be exchanged.
`timescale 1ns/1ps
module smsp_peer (
   // Clock and port pins.
   input wire logic pclk,
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic serial_data_out,
   input wire logic sdo_oe,
   output logic sck_in,
   output logic serial_data_in,
   // Bytes of the slave role.
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte
);
   logic [2:0] cnt = 3'h0;
   logic drv = 1'b0;
   logic sdi_m = 1'b0;
   initial sck_in = 1'b0;
   // Slave role: sample on the leading edge, step to the next bit on the trailing one.
   always @(posedge sck_out) begin
      if (sck_oe) begin
         // A released data line reads as the inverse, so a lost release shows up.
         rx_byte <= {rx_byte[6:0], sdo_oe ? serial_data_out : ~serial_data_out};
      end
   end
   always @(negedge sck_out) begin
      if (sck_oe) begin
         cnt <= cnt + 3'h1;
      end
   end
   // The slave role only answers clocks; it never makes one.
   assign serial_data_in = drv ? sdi_m : tx_byte[3'h7 - cnt];
   // Master role: six pclk per half period, well above the port's synchroniser delay.
   task automatic drive(input logic [7:0] tx, output logic [7:0] rx);
      int i;
      drv = 1'b1;
      for (i = 7; i >= 0; i--) begin
         sdi_m <= tx[i];
         repeat (6) @(posedge pclk);
         sck_in <= 1'b1;
         rx = {rx[6:0], serial_data_out};
         repeat (6) @(posedge pclk);
         sck_in <= 1'b0;
      end
      sdi_m <= ~tx[0];
      repeat (6) @(posedge pclk);
      drv = 1'b0;
   endtask : drive
endmodule : smsp_peer

//--- tb/smsp_port_bench.sv
// Purpose: Self-checking bench for the serial port in master and slave roles.
// Assumes: Zero-wait APB slave; timer match every five cycles.
// Notes: Data is not compared at the fastest rate, where the input synchroniser eats the margin.
`timescale 1ns/1ps
`include "smsp_defs.svh"
module smsp_port_bench;
   logic pclk, presetn, psel, penable, pwrite, sleep, timer_match, sck_in, sck_out, sck_oe, serial_data_in, serial_data_out, sdo_oe;
   logic ss_a_n, ss_b_n, pready, pslverr, ce;
   logic [7:0] paddr, tx_byte, rx_byte, got;
   logic [31:0] pwdata, prdata, rv;
   int miscompares = 0;
   int compares = 0;
   localparam logic [31:0] en_bit = 32'h0000_0001 << `SMSP_CTL_EN;
   smsp_port uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep(sleep),
      .timer_match(timer_match), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
      .sdo_oe(sdo_oe), .ss_a_n(ss_a_n), .ss_b_n(ss_b_n));
   smsp_peer peer (.pclk(pclk), .sck_out(sck_out), .sck_oe(sck_oe), .serial_data_out(serial_data_out), .sdo_oe(sdo_oe), .sck_in(sck_in),
      .serial_data_in(serial_data_in),
      .tx_byte(tx_byte), .rx_byte(rx_byte));
   // Clock and the companion timer's match pulse.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always begin
      repeat (4) @(posedge pclk);
      timer_match <= 1'b1;
      @(posedge pclk);
      timer_match <= 1'b0;
   end
   // One APB transfer; the request stands until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test;
      if (miscompares == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   // Reset values, and a write to an unmapped place that must change nothing.
   task automatic t_reset;
      logic [7:0] a;
      apb(1'b1, 8'h14, 32'hFFFF_FFFF, rv);
      for (a = 8'h00; a <= 8'h14; a += 8'h04) begin
         apb(1'b0, a, 32'h0000_0000, rv);
         check(rv, 32'h0000_0000);
      end
      check({sck_oe, sdo_oe}, 2'b00);
   endtask : t_reset
   // Every master rate with a collision write; sleep and freeze pauses; the data output released at f/64.
   task automatic t_master;
      int m, n;
      logic s;
      int half [4] = '{2, 8, 32, 5};
      for (m = 0; m < 4; m++) begin
         apb(1'b1, `SMSP_OFF_STATUS, (32'h0000_0001 << `SMSP_STA_CKE) |
            (m == 2 ? 32'h0000_0001 << `SMSP_STA_SDOREL : 32'h0000_0000), rv);
         apb(1'b1, `SMSP_OFF_CONTROL, en_bit | m, rv);
         check(sck_out, 1'b0);
         tx_byte <= 8'(8'h3C + m);
         apb(1'b1, `SMSP_OFF_BUFFER, 32'h0000_00A5 - m, rv);
         apb(1'b1, `SMSP_OFF_BUFFER, 32'h0000_00FF, rv);
         // At f/4 the first pulse is already under way here, so a whole later one is timed.
         n = 0;
         while (sck_out === 1'b1 && n++ < 400) @(posedge pclk);
         n = 0;
         while (sck_out !== 1'b1 && n++ < 400) @(posedge pclk);
         n = 0;
         while (sck_out === 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
         end
         check(n, half[m]);
         // Odd modes pause mid-byte by sleep or by the clock enable; 45 cycles span an odd number of ticks.
         if (m[0]) begin
            s = sck_out;
            if (m == 1) sleep <= 1'b1;
            else ce <= 1'b0;
            repeat (45) @(posedge pclk);
            check(sck_out, s);
            sleep <= 1'b0;
            ce <= 1'b1;
         end
         n = 0;
         do begin
            apb(1'b0, `SMSP_OFF_STATUS, 32'h0000_0000, rv);
            n++;
         end while (rv[`SMSP_STA_FULL] !== 1'b1 && n < 400);
         check(rv[`SMSP_STA_FULL], 1'b1);
         if (m == 2) check(sdo_oe, 1'b0);
         if (m != 0) check(rx_byte, m == 2 ? 32'h0000_00FF & ~(32'h0000_00A5 - m) : 32'h0000_00A5 - m);
         apb(1'b0, `SMSP_OFF_BUFFER, 32'h0000_0000, rv);
         if (m != 0) check(rv, 32'h0000_003C + m);
         apb(1'b0, `SMSP_OFF_STATUS, 32'h0000_0000, rv);
         check(rv[`SMSP_STA_FULL], 1'b0);
         apb(1'b0, `SMSP_OFF_IRQ, 32'h0000_0000, rv);
         check(rv[0], 1'b1);
         apb(1'b0, `SMSP_OFF_CONTROL, 32'h0000_0000, rv);
         check(rv[`SMSP_CTL_COLL], 1'b1);
         apb(1'b1, `SMSP_OFF_CONTROL, 32'h0000_0000, rv);
         apb(1'b1, `SMSP_OFF_IRQ, 32'h0000_0000, rv);
         apb(1'b0, `SMSP_OFF_CONTROL, 32'h0000_0000, rv);
         check(rv, 32'h0000_0000);
      end
      // A high idle level shows on the clock pin once the master is enabled; it is disabled before the slave test.
      apb(1'b1, `SMSP_OFF_CONTROL, en_bit | (32'h0000_0001 << `SMSP_CTL_IDLE), rv);
      check(sck_out, 1'b1);
      apb(1'b1, `SMSP_OFF_CONTROL, 32'h0000_0001 << `SMSP_CTL_IDLE, rv);
   endtask : t_master
   // Slave role: a byte in sleep, then an overrun that must stop further traffic.
   task automatic t_slave;
      apb(1'b1, `SMSP_OFF_CONTROL, en_bit | `SMSP_MODE_SLV, rv);
      apb(1'b1, `SMSP_OFF_BUFFER, 32'h0000_0069, rv);
      sleep <= 1'b1;
      peer.drive(8'h96, got);
      sleep <= 1'b0;
      check(got, 8'h69);
      apb(1'b0, `SMSP_OFF_IRQ, 32'h0000_0000, rv);
      check(rv[0], 1'b1);
      peer.drive(8'h5A, got);
      apb(1'b0, `SMSP_OFF_CONTROL, 32'h0000_0000, rv);
      check(rv[`SMSP_CTL_SOV], 1'b1);
      apb(1'b0, `SMSP_OFF_BUFFER, 32'h0000_0000, rv);
      check(rv, 32'h0000_0096);
      peer.drive(8'h33, got);
      apb(1'b0, `SMSP_OFF_STATUS, 32'h0000_0000, rv);
      check(rv[`SMSP_STA_FULL], 1'b0);
      apb(1'b1, `SMSP_OFF_CONTROL, 32'h0000_0000, rv);
   endtask : t_slave
   // Slave select taken from the chosen pin only.
   task automatic t_select;
      apb(1'b1, `SMSP_OFF_ALTPIN, 32'h0000_0001, rv);
      apb(1'b1, `SMSP_OFF_CONTROL, en_bit | `SMSP_MODE_SLV_SS, rv);
      ss_a_n <= 1'b0;
      ss_b_n <= 1'b1;
      repeat (6) @(posedge pclk);
      check({sdo_oe, sck_oe}, 2'b00);
      apb(1'b1, `SMSP_OFF_ALTPIN, 32'h0000_0000, rv);
      repeat (6) @(posedge pclk);
      check(sdo_oe, 1'b1);
      apb(1'b1, `SMSP_OFF_CONTROL, 32'h0000_0000, rv);
      check(sdo_oe, 1'b0);
   endtask : t_select
   // Main sequence, and a watchdog that ends a hang.
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, sleep, timer_match} = 5'b00000;
      ce = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      {ss_a_n, ss_b_n} = 2'b11;
      tx_byte = 8'h00;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_master();
      t_slave();
      t_select();
      stop_test();
   end
   initial begin
      repeat (30000) @(posedge pclk);
      miscompares++;
      stop_test();
   end
endmodule : smsp_port_bench
